// *** include/pmcs_pkg.sv ***
/*
 pmcs_pkg: constants, field positions and types for the power management
 control/status register bank. Assumes a 32-bit APB with 12-bit byte address.
*/
package pmcs_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam int PMCS_ADDR_W = 12;
	localparam logic [11:0] PMCS_OFS_CTRL = 12'h000;
	localparam logic [11:0] PMCS_OFS_BSE = 12'h004;
	localparam logic [11:0] PMCS_OFS_IRQ_STAT = 12'h008;
	localparam logic [11:0] PMCS_OFS_IRQ_MASK = 12'h00C;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int PMCS_BIT_FLAG = 15;
	localparam int PMCS_BIT_EN = 8;
	localparam int PMCS_BIT_BPCC = 7;
	localparam int PMCS_BIT_B2B3 = 6;
	localparam int PMCS_IRQ_WAKE = 0;
	localparam int PMCS_IRQ_PSCHG = 1;
	localparam int PMCS_IRQ_W = 2;

	// ------------------------------------------------------------
	// encodings and reset values
	// ------------------------------------------------------------
	localparam logic [1:0] PMCS_PS_D0 = 2'h0;
	localparam logic [1:0] PMCS_PS_D1 = 2'h1;
	localparam logic [1:0] PMCS_PS_D2 = 2'h2;
	localparam logic [1:0] PMCS_PS_D3HOT = 2'h3;
	localparam logic [1:0] PMCS_PS_RST = 2'h0;
	localparam logic [1:0] PMCS_SCALE_VAL = 2'h0;
	localparam logic [3:0] PMCS_SEL_VAL = 4'h0;
	localparam logic [7:0] PMCS_BSE_RST = 8'h00;
	localparam logic [1:0] PMCS_MASK_RST = 2'h0;
	localparam logic [31:0] PMCS_RD_ZERO = 32'h00000000;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {PMCS_B0, PMCS_B1, PMCS_B2, PMCS_B3} pmcs_bus_e;

	typedef struct packed {
		pmcs_bus_e bus_state;
		logic clk_stop;
		logic pwr_off;
	} pmcs_sec_s;

endpackage

// *** rtl/pmcs_top.sv ***
/*
 pmcs_top: power management control/status bank for one function, with
 wake flag/enable, power state, bridge support extension, secondary bus
 control and an interrupt. Assumes an APB master on clk_sys_i, a wake
 pulse from function logic on the same clock, and asynchronous strap pins.
*/
// Design decisions made here: the APB register port and the register addresses.
// Operation
// - wake flag sets on every event, enable ignored
// - writing one clears flag; zero leaves it
// - flag and enable survive function reset if supported
// - wake pin driven only while enable set
// - data scale field reads zero, read-only
// - data select field reads zero, writes dropped
// - power state field reads and writes D0..D3hot
// - unsupported state write completes but is dropped
// - bridge extension register read-only, resets zero
// - bus control enable gates secondary bus control
// - D3hot stops clock or removes power per bit
// - secondary bus state follows function power state
// - strap at power-on decides cold wake support
`timescale 1ns/1ps
`default_nettype none

module pmcs_top
	import pmcs_pkg::*;
#(
	parameter bit D1_SUPPORTED = 1'b1,
	parameter bit D2_SUPPORTED = 1'b1
) (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic func_rst_i,
	input wire logic wake_event_i,
	input wire logic d3cold_wake_strap_pin_i,
	input wire logic bpcc_strap_i,
	input wire logic b2b3_strap_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [PMCS_ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic pme_out_o,
	output logic pme_oe_o,
	output pmcs_sec_s sec_bus_o,
	output logic d3cold_wake_supported_o,
	output logic irq_o
);

	// ------------------------------------------------------------
	// strap synchronisers
	// ------------------------------------------------------------
	// straps are pins: three flops, the 2nd and 3rd must agree before capture
	logic [2:0] strap_pin;
	logic [2:0] strap_s1_reg;
	logic [2:0] strap_s2_reg;
	logic [2:0] strap_s3_reg;
	logic [2:0] fill_reg;
	logic strap_taken_reg;
	logic d3cold_sup_reg;
	logic [7:0] bse_reg;

	assign strap_pin = {d3cold_wake_strap_pin_i, bpcc_strap_i, b2b3_strap_i};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			always_ff @(posedge clk_sys_i) begin
				if (srst_i) begin
					strap_s1_reg[gi] <= 1'b0;
					strap_s2_reg[gi] <= 1'b0;
					strap_s3_reg[gi] <= 1'b0;
				end else begin
					strap_s1_reg[gi] <= strap_pin[gi];
					strap_s2_reg[gi] <= strap_s1_reg[gi];
					strap_s3_reg[gi] <= strap_s2_reg[gi];
				end
			end
		end
	endgenerate

	// the chain still holds reset zeros for three cycles, which must not be captured
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			fill_reg <= 3'h0;
		end else begin
			fill_reg <= {fill_reg[1:0], 1'b1};
		end
	end

	// capture once after release; the bridge bits are read-only copies of straps
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			strap_taken_reg <= 1'b0;
			d3cold_sup_reg <= 1'b0;
			bse_reg <= PMCS_BSE_RST;
		end else if (fill_reg[2] && !strap_taken_reg && (strap_s2_reg == strap_s3_reg)) begin
			strap_taken_reg <= 1'b1;
			d3cold_sup_reg <= strap_s3_reg[2];
			bse_reg[PMCS_BIT_BPCC] <= strap_s3_reg[1];
			bse_reg[PMCS_BIT_B2B3] <= strap_s3_reg[0];
		end
	end

	assign d3cold_wake_supported_o = d3cold_sup_reg;

	// ------------------------------------------------------------
	// apb slave
	// ------------------------------------------------------------
	// no wait state: pready and read data are registered in the setup cycle so every bus output comes from a flop
	logic pready_reg;
	logic [31:0] prdata_reg;
	logic pslverr_reg;
	logic mapped;
	logic wr_acc;
	logic wr_ctrl;
	logic wr_stat;
	logic wr_mask;
	logic [31:0] rd_mux;
	logic wake_flag_reg;
	logic wake_en_reg;
	logic [1:0] ps_reg;
	logic [PMCS_IRQ_W-1:0] irq_stat_reg;
	logic [PMCS_IRQ_W-1:0] irq_mask_reg;

	assign mapped = (paddr_i == PMCS_OFS_CTRL) || (paddr_i == PMCS_OFS_BSE) ||
		(paddr_i == PMCS_OFS_IRQ_STAT) || (paddr_i == PMCS_OFS_IRQ_MASK);
	assign wr_acc = psel_i && penable_i && pready_reg && pwrite_i && mapped;
	assign wr_ctrl = wr_acc && (paddr_i == PMCS_OFS_CTRL);
	assign wr_stat = wr_acc && (paddr_i == PMCS_OFS_IRQ_STAT);
	assign wr_mask = wr_acc && (paddr_i == PMCS_OFS_IRQ_MASK);

	always_comb begin
		rd_mux = PMCS_RD_ZERO;
		case (paddr_i)
			PMCS_OFS_CTRL: begin
				rd_mux[PMCS_BIT_FLAG] = wake_flag_reg;
				rd_mux[14:13] = PMCS_SCALE_VAL;
				rd_mux[12:9] = PMCS_SEL_VAL;
				rd_mux[PMCS_BIT_EN] = wake_en_reg;
				rd_mux[1:0] = ps_reg;
			end
			PMCS_OFS_BSE: rd_mux[7:0] = bse_reg;
			PMCS_OFS_IRQ_STAT: rd_mux[PMCS_IRQ_W-1:0] = irq_stat_reg;
			PMCS_OFS_IRQ_MASK: rd_mux[PMCS_IRQ_W-1:0] = irq_mask_reg;
			default: rd_mux = PMCS_RD_ZERO;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			pready_reg <= 1'b0;
			prdata_reg <= PMCS_RD_ZERO;
			pslverr_reg <= 1'b0;
		end else if (psel_i && !penable_i && !pready_reg) begin
			pready_reg <= 1'b1;
			prdata_reg <= pwrite_i ? PMCS_RD_ZERO : rd_mux;
			pslverr_reg <= !mapped;
		end else begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end
	end

	assign pready_o = pready_reg;
	assign prdata_o = prdata_reg;
	assign pslverr_o = pslverr_reg;

	// ------------------------------------------------------------
	// wake flag and enable
	// ------------------------------------------------------------
	logic flag_clr;
	logic sticky_keep;
	logic pme_oe_reg;

	// reserved bits 7:2 are ignored on write, software keeps them zero
	assign flag_clr = wr_ctrl && pstrb_i[1] && pwdata_i[PMCS_BIT_FLAG];
	assign sticky_keep = d3cold_sup_reg;

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			wake_flag_reg <= 1'b0;
		end else if (wake_event_i) begin
			wake_flag_reg <= 1'b1;
		end else if (flag_clr) begin
			wake_flag_reg <= 1'b0;
		end else if (func_rst_i && !sticky_keep) begin
			wake_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			wake_en_reg <= 1'b0;
		end else if (func_rst_i) begin
			wake_en_reg <= sticky_keep ? wake_en_reg : 1'b0;
		end else if (wr_ctrl && pstrb_i[1]) begin
			wake_en_reg <= pwdata_i[PMCS_BIT_EN];
		end
	end

	// open drain: only ever pulls low, never drives high
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			pme_oe_reg <= 1'b0;
		end else begin
			pme_oe_reg <= wake_flag_reg && wake_en_reg && !flag_clr;
		end
	end

	assign pme_oe_o = pme_oe_reg;
	always_ff @(posedge clk_sys_i) begin
		pme_out_o <= 1'b0;
	end

	// ------------------------------------------------------------
	// power state
	// ------------------------------------------------------------
	logic [1:0] ps_wr;
	logic ps_ok;
	logic ps_chg;

	assign ps_wr = pwdata_i[1:0];
	assign ps_ok = (ps_wr == PMCS_PS_D0) || (ps_wr == PMCS_PS_D3HOT) ||
		((ps_wr == PMCS_PS_D1) && D1_SUPPORTED) || ((ps_wr == PMCS_PS_D2) && D2_SUPPORTED);
	assign ps_chg = wr_ctrl && pstrb_i[0] && ps_ok && (ps_wr != ps_reg);

	always_ff @(posedge clk_sys_i) begin
		if (srst_i || func_rst_i) begin
			ps_reg <= PMCS_PS_RST;
		end else if (wr_ctrl && pstrb_i[0] && ps_ok) begin
			ps_reg <= ps_wr;
		end
	end

	// ------------------------------------------------------------
	// secondary bus control
	// ------------------------------------------------------------
	pmcs_sec_s sec_reg;

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			sec_reg <= '{bus_state: PMCS_B0, clk_stop: 1'b0, pwr_off: 1'b0};
		end else if (!bse_reg[PMCS_BIT_BPCC]) begin
			sec_reg <= '{bus_state: PMCS_B0, clk_stop: 1'b0, pwr_off: 1'b0};
		end else begin
			case (ps_reg)
				PMCS_PS_D0: sec_reg <= '{bus_state: PMCS_B0, clk_stop: 1'b0, pwr_off: 1'b0};
				PMCS_PS_D1: sec_reg <= '{bus_state: PMCS_B1, clk_stop: 1'b0, pwr_off: 1'b0};
				PMCS_PS_D2: sec_reg <= '{bus_state: PMCS_B2, clk_stop: 1'b1, pwr_off: 1'b0};
				PMCS_PS_D3HOT: begin
					if (bse_reg[PMCS_BIT_B2B3]) begin
						sec_reg <= '{bus_state: PMCS_B2, clk_stop: 1'b1, pwr_off: 1'b0};
					end else begin
						sec_reg <= '{bus_state: PMCS_B3, clk_stop: 1'b1, pwr_off: 1'b1};
					end
				end
				default: sec_reg <= '{bus_state: PMCS_B0, clk_stop: 1'b0, pwr_off: 1'b0};
			endcase
		end
	end

	assign sec_bus_o = sec_reg;

	// ------------------------------------------------------------
	// interrupt
	// ------------------------------------------------------------
	logic [PMCS_IRQ_W-1:0] irq_evt;
	logic [PMCS_IRQ_W-1:0] irq_clr;
	logic irq_reg;

	assign irq_evt = {ps_chg, wake_event_i};
	assign irq_clr = (wr_stat && pstrb_i[0]) ? pwdata_i[PMCS_IRQ_W-1:0] : '0;

	// set wins over a clear in the same cycle
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			irq_stat_reg <= '0;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_evt;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			irq_mask_reg <= PMCS_MASK_RST;
		end else if (wr_mask && pstrb_i[0]) begin
			irq_mask_reg <= pwdata_i[PMCS_IRQ_W-1:0];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(((irq_stat_reg & ~irq_clr) | irq_evt) & irq_mask_reg);
		end
	end

	assign irq_o = irq_reg;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);

	sequence s_d3hot_write;
		bse_reg[PMCS_BIT_BPCC] && wr_ctrl && pstrb_i[0] && (pwdata_i[1:0] == PMCS_PS_D3HOT);
	endsequence

	sequence s_bus_settles;
		##2 sec_bus_o.clk_stop;
	endsequence

	a_flag_sets: assert property (wake_event_i |=> wake_flag_reg)
		else $error("wake flag not set by event");
	a_flag_clears: assert property (flag_clr && !wake_event_i |=> !wake_flag_reg)
		else $error("wake flag not cleared by one");
	a_flag_zero_write: assert property (wr_ctrl && !pwdata_i[PMCS_BIT_FLAG] && wake_flag_reg
		|=> wake_flag_reg)
		else $error("wake flag lost on zero write");
	a_sticky_keep: assert property (func_rst_i && d3cold_sup_reg && !srst_i
		|=> $stable(wake_en_reg))
		else $error("sticky enable lost on function reset");
	a_nosticky_clear: assert property (func_rst_i && !d3cold_sup_reg && !wake_event_i
		|=> !wake_flag_reg && !wake_en_reg)
		else $error("wake bits kept without support");
	a_pme_gate: assert property (!wake_en_reg |=> !pme_oe_o)
		else $error("wake pin driven while disabled");
	a_pme_drive: assert property (wake_flag_reg && wake_en_reg && !flag_clr |=> pme_oe_o)
		else $error("wake pin not driven");
	a_scale_select: assert property (pready_o && !pwrite_i && paddr_i == PMCS_OFS_CTRL
		|-> prdata_o[14:9] == 6'h00)
		else $error("scale or select field not zero");
	a_state_write: assert property (wr_ctrl && pstrb_i[0] && ps_ok && !func_rst_i
		|=> ps_reg == $past(pwdata_i[1:0]))
		else $error("power state write not taken");
	a_state_drop: assert property (wr_ctrl && !ps_ok && !func_rst_i |=> $stable(ps_reg))
		else $error("unsupported state accepted");
	a_strobe_gate: assert property (wr_ctrl && !pstrb_i[0] && !func_rst_i
		|=> $stable(ps_reg))
		else $error("unstrobed byte written");
	a_bse_stable: assert property (strap_taken_reg |=> $stable(bse_reg) && bse_reg[5:0] == 6'h00)
		else $error("bridge register changed");
	a_bus_disabled: assert property (!bse_reg[PMCS_BIT_BPCC] |=> sec_bus_o.bus_state == PMCS_B0
		&& !sec_bus_o.clk_stop && !sec_bus_o.pwr_off)
		else $error("secondary bus controlled while disabled");
	a_d3hot_action: assert property (s_d3hot_write
		##1 $stable(bse_reg) && !func_rst_i |-> ##1 sec_bus_o.clk_stop
		&& (sec_bus_o.pwr_off == !bse_reg[PMCS_BIT_B2B3]))
		else $error("wrong D3hot bus action");
	a_d2_clock: assert property (bse_reg[PMCS_BIT_BPCC] && ps_reg == PMCS_PS_D2
		|=> sec_bus_o.bus_state == PMCS_B2 && sec_bus_o.clk_stop)
		else $error("D2 did not stop clock");
	a_d3_settles: assert property (s_d3hot_write ##1 !func_rst_i
		&& bse_reg[PMCS_BIT_BPCC] |-> s_bus_settles)
		else $error("D3hot clock not stopped");
	a_strap_take: assert property (fill_reg[2] && !strap_taken_reg && strap_s2_reg == strap_s3_reg
		|=> d3cold_sup_reg == $past(strap_s3_reg[2]))
		else $error("strap not captured");

endmodule

`default_nettype wire

// *** dv/pmcs_host.sv ***
/*
 pmcs_host: host-side APB master that issues register accesses to the
 power management bank. Assumes one clock and a slave that answers with
 pready; the bench calls xfer hierarchically, one transfer at a time.
*/
`timescale 1ns/1ps
`default_nettype none

module pmcs_host (
	input wire logic clk_sys_i,
	output logic psel_o,
	output logic penable_o,
	output logic pwrite_o,
	output logic [11:0] paddr_o,
	output logic [31:0] pwdata_o,
	output logic [3:0] pstrb_o,
	input wire logic [31:0] prdata_i,
	input wire logic pready_i,
	input wire logic pslverr_i
);
	// ------------------------------------------------------------
	// idle values
	// ------------------------------------------------------------
	initial begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 12'hFFF;
		pwdata_o = 32'h5A5A5A5A;
		pstrb_o = 4'h0;
	end

	// ------------------------------------------------------------
	// one transfer: setup, access held until pready
	// ------------------------------------------------------------
	// released address and data are inverted so stale values never look valid
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] r, output logic e);
		@(posedge clk_sys_i);
		psel_o <= 1'b1;
		penable_o <= 1'b0;
		pwrite_o <= w;
		paddr_o <= a;
		pwdata_o <= d;
		pstrb_o <= w ? s : 4'h0;
		@(posedge clk_sys_i);
		penable_o <= 1'b1;
		do @(posedge clk_sys_i); while (pready_i !== 1'b1);
		r = prdata_i;
		e = pslverr_i;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		paddr_o <= ~a;
		pwdata_o <= ~d;
	endtask
endmodule

`default_nettype wire

// *** dv/testbench.sv ***
/*
 testbench: self-checking bench for pmcs_top with D1 unsupported. Assumes
 the host model above, straps captured within 8 cycles of reset release.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench
	import pmcs_pkg::*;
;
	logic clk_sys_i = 1'b0, srst_i = 1'b1, func_rst_i = 1'b0, wake_event_i = 1'b0;
	logic strap_cw = 1'b1, strap_bp = 1'b1, strap_b3 = 1'b1;
	wire logic psel, penable, pwrite;
	wire logic [11:0] paddr;
	wire logic [31:0] pwdata;
	wire logic [3:0] pstrb;
	logic [31:0] prdata, rdat, v;
	logic pready, pslverr, pme_out, pme_oe, cw_sup, irq, rerr;
	pmcs_sec_s sec;
	logic [1:0] ps;
	int n_mismatch = 0, checked = 0, seed = 32'ha4f2;

	always #20 clk_sys_i = ~clk_sys_i;

	pmcs_host u_host (.clk_sys_i(clk_sys_i), .psel_o(psel), .penable_o(penable),
		.pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata), .pstrb_o(pstrb),
		.prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr));

	pmcs_top #(.D1_SUPPORTED(1'b0), .D2_SUPPORTED(1'b1)) u_dut (.clk_sys_i(clk_sys_i),
		.srst_i(srst_i), .func_rst_i(func_rst_i), .wake_event_i(wake_event_i),
		.d3cold_wake_strap_pin_i(strap_cw), .bpcc_strap_i(strap_bp), .b2b3_strap_i(strap_b3),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .pme_out_o(pme_out), .pme_oe_o(pme_oe), .sec_bus_o(sec),
		.d3cold_wake_supported_o(cw_sup), .irq_o(irq));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		u_host.xfer(w, a, d, s, rdat, rerr);
	endtask

	task cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask

	task do_reset(input logic cw, input logic bp, input logic b3);
		@(posedge clk_sys_i);
		srst_i <= 1'b1;
		strap_cw <= cw;
		strap_bp <= bp;
		strap_b3 <= b3;
		cyc(6);
		srst_i <= 1'b0;
		cyc(8);
	endtask

	task pulse(input logic rst_sel);
		@(posedge clk_sys_i);
		if (rst_sel) begin
			func_rst_i <= 1'b1;
		end else begin
			wake_event_i <= 1'b1;
		end
		@(posedge clk_sys_i);
		func_rst_i <= 1'b0;
		wake_event_i <= 1'b0;
		cyc(3);
	endtask

	// secondary bus as {bus_state, clk_stop, pwr_off}
	function logic [3:0] exp_sec(input logic [1:0] p, input logic bp, input logic b3);
		if (!bp || p == PMCS_PS_D0) return {PMCS_B0, 2'b00};
		if (p == PMCS_PS_D1) return {PMCS_B1, 2'b00};
		if (p == PMCS_PS_D2 || b3) return {PMCS_B2, 2'b10};
		return {PMCS_B3, 2'b11};
	endfunction

	task ps_chk(input logic [1:0] p, input logic bp, input logic b3);
		acc(1'b1, PMCS_OFS_CTRL, {30'h0, p}, 4'h1);
		cyc(3);
		chk("sec_bus", {28'h0, sec}, {28'h0, exp_sec(p, bp, b3)});
	endtask

	task final_report;
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// watchdog
	// ------------------------------------------------------------
	// the run needs well under 2000 cycles, so 20000 only trips on a hang
	initial begin
		#(40 * 20000);
		n_mismatch++;
		final_report();
	end

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial begin
		do_reset(1'b1, 1'b1, 1'b1);
		chk("cold_wake_sup", {31'h0, cw_sup}, 32'h1);
		acc(1'b1, PMCS_OFS_BSE, 32'h0000003F, 4'hF);
		acc(1'b0, PMCS_OFS_BSE, 32'h0, 4'h0);
		chk("bse", rdat, 32'h000000C0);
		acc(1'b0, 12'h010, 32'h0, 4'h0);
		chk("unmapped", {rdat[30:0], rerr}, 32'h1);
		acc(1'b0, PMCS_OFS_CTRL, 32'h0, 4'h0);
		chk("ctrl_rst", rdat, 32'h0);
		ps = PMCS_PS_D0;
		for (int i = 0; i < 8; i++) begin
			v = ($random(seed) & 32'h00007F00) | (i & 3);
			acc(1'b1, PMCS_OFS_CTRL, v, 4'h3);
			chk("ps_err", {31'h0, rerr}, 32'h0);
			if (v[1:0] != PMCS_PS_D1) ps = v[1:0];
			acc(1'b0, PMCS_OFS_CTRL, 32'h0, 4'h0);
			chk("ctrl", rdat, {16'h0, 7'h00, v[8], 6'h00, ps});
			cyc(3);
			chk("sec_bus", {28'h0, sec}, {28'h0, exp_sec(ps, 1'b1, 1'b1)});
		end
		acc(1'b1, PMCS_OFS_IRQ_STAT, 32'h3, 4'hF);
		acc(1'b1, PMCS_OFS_IRQ_MASK, 32'h1, 4'hF);
		acc(1'b1, PMCS_OFS_CTRL, 32'h0, 4'h2);
		pulse(1'b0);
		acc(1'b0, PMCS_OFS_CTRL, 32'h0, 4'h0);
		chk("flag_set", {31'h0, rdat[15]}, 32'h1);
		chk("pme_off", {31'h0, pme_oe}, 32'h0);
		chk("irq_on", {31'h0, irq}, 32'h1);
		acc(1'b1, PMCS_OFS_IRQ_MASK, 32'h0, 4'hF);
		cyc(2);
		chk("irq_masked", {31'h0, irq}, 32'h0);
		acc(1'b1, PMCS_OFS_IRQ_STAT, 32'h1, 4'hF);
		acc(1'b1, PMCS_OFS_IRQ_MASK, 32'h1, 4'hF);
		cyc(2);
		acc(1'b0, PMCS_OFS_IRQ_STAT, 32'h0, 4'h0);
		chk("irq_stat", {rdat[30:0], irq}, 32'h0);
		acc(1'b1, PMCS_OFS_CTRL, 32'h0100, 4'h2);
		cyc(3);
		chk("pme_on", {30'h0, pme_oe, pme_out}, 32'h2);
		acc(1'b1, PMCS_OFS_CTRL, 32'h8100 | ps, 4'h1);
		acc(1'b1, PMCS_OFS_CTRL, 32'h0100, 4'h2);
		acc(1'b0, PMCS_OFS_CTRL, 32'h0, 4'h0);
		chk("flag_kept", rdat, 32'h8100 | ps);
		pulse(1'b1);
		acc(1'b0, PMCS_OFS_CTRL, 32'h0, 4'h0);
		chk("sticky", rdat, 32'h8100 | PMCS_PS_D0);
		acc(1'b1, PMCS_OFS_CTRL, 32'h8100, 4'h2);
		cyc(2);
		chk("pme_clr", {31'h0, pme_oe}, 32'h0);
		acc(1'b0, PMCS_OFS_CTRL, 32'h0, 4'h0);
		chk("flag_clr", rdat, 32'h0100);
		do_reset(1'b0, 1'b1, 1'b0);
		chk("cold_wake_none", {31'h0, cw_sup}, 32'h0);
		acc(1'b0, PMCS_OFS_BSE, 32'h0, 4'h0);
		chk("bse_b3", rdat, 32'h00000080);
		acc(1'b1, PMCS_OFS_CTRL, 32'h0100, 4'h2);
		pulse(1'b0);
		pulse(1'b1);
		acc(1'b0, PMCS_OFS_CTRL, 32'h0, 4'h0);
		chk("not_sticky", rdat, 32'h0);
		ps_chk(PMCS_PS_D3HOT, 1'b1, 1'b0);
		ps_chk(PMCS_PS_D0, 1'b1, 1'b0);
		do_reset(1'b1, 1'b0, 1'b1);
		ps_chk(PMCS_PS_D3HOT, 1'b0, 1'b1);
		final_report();
	end
endmodule

`default_nettype wire
